// *** core/uff_pkg.sv ***
/*
 Package for the upstream frame fragmenter: register offsets, field
 positions, reset values, state encodings and timing constants.
 Assumes a 100 MHz APB clock and 32-bit register words.
*/
package uff_pkg;
	// Register byte offsets
	localparam logic [7:0] UFF_CTRL = 8'h00;
	localparam logic [7:0] UFF_FRAME = 8'h04;
	localparam logic [7:0] UFF_GRANT = 8'h08;
	localparam logic [7:0] UFF_STAT = 8'h0C;
	localparam logic [7:0] UFF_IRQ = 8'h10;
	localparam logic [7:0] UFF_MASK = 8'h14;
	localparam logic [7:0] UFF_FRAG = 8'h18;
	localparam logic [7:0] UFF_REQ = 8'h1C;
	localparam logic [7:0] UFF_RETRY = 8'h20;
	// Control field positions
	localparam int UFF_C_MODEM_EN = 0;
	localparam int UFF_C_FLOW_EN = 1;
	localparam int UFF_C_ENCRYPT = 2;
	localparam int UFF_C_START = 3;
	// Grant word field positions
	localparam int UFF_G_LEN_LSB = 0;
	localparam int UFF_G_PEND = 16;
	localparam int UFF_G_IMM = 17;
	localparam int UFF_G_MORE = 18;
	// Interrupt status bit positions
	localparam int UFF_I_FRAG = 0;
	localparam int UFF_I_DONE = 1;
	localparam int UFF_I_DROP = 2;
	localparam int UFF_I_REQ = 3;
	localparam int UFF_IRQ_W = 4;
	// Sizes and reset values
	localparam logic [15:0] UFF_FRAG_OVH = 16'h0010;
	localparam logic [15:0] UFF_PHY_OVH_RST = 16'h0008;
	localparam logic [3:0] UFF_RETRY_RST = 4'h4;
	localparam logic [15:0] UFF_ACK_RST = 16'h03E8;
	// Link timing
	localparam int UFF_CLK_MHZ = 100;
	localparam int UFF_BACKOFF_NS = 200;
	localparam int UFF_BACKOFF_CYC = (UFF_BACKOFF_NS * UFF_CLK_MHZ + 999) / 1000;
	typedef enum logic [4:0] {
		UFF_IDLE = 5'b00001,
		UFF_WAIT = 5'b00010,
		UFF_SEND = 5'b00100,
		UFF_BACK = 5'b01000,
		UFF_DROP = 5'b10000
	} uff_state_t;
endpackage

// *** core/uff_fragmenter.sv ***
/*
 Upstream frame fragmenter, modem side. Software loads a frame length and
 starts a request; grant map entries arrive as APB writes of the grant word.
 A used grant yields one transmit descriptor (payload length, flags, sequence,
 piggyback size, encryption span). Assumes one clock and APB from software.
*/
// Behaviour
// (R1) Headend enables fragmentation per modem, then per flow by policy setting.
// (R2) Fragmenting starts only on an enabled flow given fewer slots than asked.
// (R3) Partial grant is filled with largest payload after all overheads.
// (R4) With no later grant or pending entry, piggyback a request on the fragment.
// (R5) While fragmenting, piggyback travels in the privacy extension header.
// (R6) Remainder request covers remaining frame plus 16 bytes plus physical overhead.
// (R7) No grant within acknowledgement time: back off, re-request, up to threshold.
// (R8) Past the retry threshold, drop all untransmitted frame data.
// (R9) First fragment F=1 L=0, middle both clear, last L=1 F=0.
// (R10) Sequence number rises by one per transmitted fragment.
// (R11) Encryption per fragment, from after header check through fragment CRC.
// (R12) Never fragment a frame sent in an immediate request-with-data region.
// (R13) Fragment is frame slice between fixed header and fragment CRC.
// (R14) Untransmitted portion is whole frame, then the unsent remainder.
// (R15) With grants already queued, the piggyback field is zero.
// (R16) Multiple-grant headend repeats zero-length pending entries until granting.
// (R17) Grant large enough with no fragmentation in progress: send unfragmented.
module uff_fragmenter
	import uff_pkg::*;
#(
	parameter logic [15:0] ACK_CYCLES = UFF_ACK_RST // Acknowledgement time in cycles
) (
	input wire logic pclk, // APB clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic irq, // Level interrupt
	output logic tx_valid, // Descriptor pulse
	output logic [15:0] tx_payload, // Frame bytes in this burst
	output logic tx_frag, // Fragment header present
	output logic tx_first, // First flag
	output logic tx_last, // Last flag
	output logic [3:0] tx_seq, // Fragment sequence
	output logic [15:0] tx_piggy, // Piggyback request bytes
	output logic tx_piggy_ehdr, // Piggyback in privacy extension header
	output logic tx_encrypt, // Encrypt header check to CRC
	output logic req_valid, // Bandwidth request pulse
	output logic [15:0] req_bytes // Requested bytes
);
	import uff_pkg::*;

	uff_state_t state_q;
	logic [3:0] ctrl_q;
	logic [15:0] remain_q;
	logic [15:0] phy_q;
	logic [3:0] retry_max_q;
	logic [3:0] retry_q;
	logic [15:0] timer_q;
	logic [15:0] backoff_q;
	logic fragging_q;
	logic [UFF_IRQ_W-1:0] stat_q;
	logic [UFF_IRQ_W-1:0] mask_q;
	logic [UFF_IRQ_W-1:0] ev;
	logic wr, rd, hit_grant, start;
	logic frag_on, partial;
	logic [15:0] glen, cap, need_full, need_rem;
	logic [7:0] a;
	logic rd_ack_q;

	// APB decode: writes answer at once, reads one cycle later
	assign a = paddr[7:0];
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = !rd || rd_ack_q; // Read data is registered first
	assign pslverr = psel && penable && (paddr[31:6] != 26'h0 || a[1:0] != 2'h0 || a > UFF_RETRY);
	assign start = wr && a == UFF_CTRL && pwdata[UFF_C_START] && state_q == UFF_IDLE;
	assign hit_grant = wr && a == UFF_GRANT && state_q == UFF_WAIT;
	assign glen = pwdata[UFF_G_LEN_LSB +: 16];

	// Fragmentation allowed only when both enables set
	assign frag_on = ctrl_q[UFF_C_MODEM_EN] && ctrl_q[UFF_C_FLOW_EN]; // R1
	// Need for whole frame and for a fragmented remainder
	assign need_full = 16'(remain_q + phy_q); // R14
	assign need_rem = 16'(remain_q + UFF_FRAG_OVH + phy_q); // R6
	assign cap = (glen > 16'(UFF_FRAG_OVH + phy_q)) ? 16'(glen - UFF_FRAG_OVH - phy_q) : 16'h0000; // R3
	// Partial grant: fragmenting and remainder does not fit, or new frame short
	assign partial = fragging_q ? (glen < need_rem) : (glen < need_full); // R2

	// Control and configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 4'h0;
			phy_q <= UFF_PHY_OVH_RST;
			retry_max_q <= UFF_RETRY_RST;
		end else if (wr) begin
			if (a == UFF_CTRL) begin
				ctrl_q <= {1'b0, pwdata[2:0]};
			end
			if (a == UFF_RETRY) begin
				retry_max_q <= pwdata[3:0];
				phy_q <= pwdata[31:16];
			end
		end
	end

	// Main sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= UFF_IDLE;
			remain_q <= 16'h0000;
			fragging_q <= 1'b0;
			retry_q <= 4'h0;
			timer_q <= 16'h0000;
			backoff_q <= 16'h0000;
			tx_valid <= 1'b0;
			tx_payload <= 16'h0000;
			tx_frag <= 1'b0;
			tx_first <= 1'b0;
			tx_last <= 1'b0;
			tx_seq <= 4'h0;
			tx_piggy <= 16'h0000;
			tx_piggy_ehdr <= 1'b0;
			tx_encrypt <= 1'b0;
			req_valid <= 1'b0;
			req_bytes <= 16'h0000;
		end else begin
			tx_valid <= 1'b0;
			req_valid <= 1'b0;
			case (state_q)
				UFF_IDLE: begin
					if (start) begin
						remain_q <= 16'(pwdata[31:16]); // R14
						fragging_q <= 1'b0;
						retry_q <= 4'h0;
						timer_q <= ACK_CYCLES;
						req_valid <= 1'b1;
						req_bytes <= 16'(pwdata[31:16] + phy_q);
						state_q <= UFF_WAIT;
					end
				end
				UFF_WAIT: begin
					if (hit_grant) begin
						timer_q <= ACK_CYCLES;
						if (pwdata[UFF_G_PEND] && glen == 16'h0000) begin
							// Pending entry only: keep waiting, reload timer
						end else if (partial && frag_on && !pwdata[UFF_G_IMM]) begin // R2 R12
							tx_valid <= 1'b1;
							tx_frag <= 1'b1; // R13
							tx_payload <= (cap < remain_q) ? cap : remain_q; // R3
							tx_first <= !fragging_q; // R9
							tx_last <= 1'b0; // R9
							tx_seq <= fragging_q ? 4'(tx_seq + 4'h1) : 4'h0; // R10
							tx_encrypt <= ctrl_q[UFF_C_ENCRYPT]; // R11
							tx_piggy_ehdr <= 1'b1; // R5
							// Piggyback only if no later grant is queued
							tx_piggy <= pwdata[UFF_G_MORE] ? 16'h0000 :
								16'(remain_q - cap + UFF_FRAG_OVH + phy_q); // R4 R6 R15
							remain_q <= 16'(remain_q - cap); // R14
							fragging_q <= 1'b1;
							retry_q <= 4'h0;
						end else if (!partial) begin
							// Whole frame or final fragment; a short grant is left unused
							tx_valid <= 1'b1;
							tx_payload <= remain_q;
							tx_frag <= fragging_q; // R17
							tx_first <= 1'b0; // R9
							tx_last <= fragging_q; // R9
							tx_seq <= fragging_q ? 4'(tx_seq + 4'h1) : 4'h0; // R10
							tx_encrypt <= ctrl_q[UFF_C_ENCRYPT];
							tx_piggy <= 16'h0000;
							tx_piggy_ehdr <= 1'b0;
							remain_q <= 16'h0000;
							fragging_q <= 1'b0;
							state_q <= UFF_IDLE;
						end
					end else if (timer_q == 16'h0000) begin
						if (retry_q >= retry_max_q) begin // R8
							state_q <= UFF_DROP;
						end else begin
							retry_q <= 4'(retry_q + 4'h1); // R7
							backoff_q <= 16'(UFF_BACKOFF_CYC * (retry_q + 1));
							state_q <= UFF_BACK;
						end
					end else begin
						timer_q <= 16'(timer_q - 16'h0001);
					end
				end
				UFF_BACK: begin
					if (backoff_q == 16'h0000) begin
						req_valid <= 1'b1; // R7
						req_bytes <= fragging_q ? need_rem : need_full; // R6 R14
						timer_q <= ACK_CYCLES;
						state_q <= UFF_WAIT;
					end else begin
						backoff_q <= 16'(backoff_q - 16'h0001);
					end
				end
				UFF_DROP: begin
					remain_q <= 16'h0000; // R8
					fragging_q <= 1'b0;
					state_q <= UFF_IDLE;
				end
				default: begin
					state_q <= UFF_IDLE;
				end
			endcase
		end
	end

	// Events: set wins over write-one-clear
	assign ev[UFF_I_FRAG] = tx_valid && tx_frag;
	assign ev[UFF_I_DONE] = tx_valid && (!tx_frag || tx_last);
	assign ev[UFF_I_DROP] = state_q == UFF_DROP;
	assign ev[UFF_I_REQ] = req_valid;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= '0;
			mask_q <= '0;
		end else begin
			stat_q <= (stat_q & ~((wr && a == UFF_IRQ) ? pwdata[UFF_IRQ_W-1:0] : '0)) | ev;
			if (wr && a == UFF_MASK) begin
				mask_q <= pwdata[UFF_IRQ_W-1:0];
			end
		end
	end
	assign irq = |(stat_q & mask_q);

	// Read data registered in the first access cycle, answered in the next
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ack_q <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			rd_ack_q <= rd && !rd_ack_q;
			if (rd && !rd_ack_q) begin
				case (a)
					UFF_CTRL: prdata <= {28'h0, ctrl_q};
					UFF_FRAME: prdata <= {16'h0, remain_q};
					UFF_STAT: prdata <= {8'h0, retry_q, 3'h0, fragging_q, 11'h0, state_q};
					UFF_IRQ: prdata <= {28'h0, stat_q};
					UFF_MASK: prdata <= {28'h0, mask_q};
					UFF_FRAG: prdata <= {12'h0, tx_seq, tx_payload};
					UFF_REQ: prdata <= {16'h0, req_bytes};
					UFF_RETRY: prdata <= {phy_q, 12'h0, retry_max_q};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Checks on flags, sizes and the retry sequence
	a_first_flags: assert property (@(posedge pclk) disable iff (!presetn) // R9
		tx_valid && tx_first |-> tx_frag && !tx_last) else $error("first flag wrong");
	a_last_flags: assert property (@(posedge pclk) disable iff (!presetn) // R9
		tx_valid && tx_last |-> !tx_first) else $error("last flag wrong");
	a_seq_step: assert property (@(posedge pclk) disable iff (!presetn) // R10
		tx_valid && tx_frag && !tx_first |-> tx_seq == 4'($past(tx_seq) + 4'h1))
		else $error("sequence skip");
	a_first_seq: assert property (@(posedge pclk) disable iff (!presetn) // R10
		tx_valid && tx_first |-> tx_seq == 4'h0) else $error("first sequence not zero");
	a_piggy_ehdr: assert property (@(posedge pclk) disable iff (!presetn) // R5
		tx_valid && tx_piggy != 16'h0 |-> tx_piggy_ehdr && tx_frag) else $error("piggy place");
	a_piggy_size: assert property (@(posedge pclk) disable iff (!presetn) // R6
		tx_valid && tx_piggy != 16'h0 |-> tx_piggy == 16'(remain_q + UFF_FRAG_OVH + phy_q))
		else $error("piggy size");
	a_partial_fill: assert property (@(posedge pclk) disable iff (!presetn) // R3
		hit_grant && partial && frag_on && !pwdata[UFF_G_IMM]
		&& glen > 16'(UFF_FRAG_OVH + phy_q)
		|=> tx_valid && tx_frag && tx_payload == 16'($past(glen) - UFF_FRAG_OVH - phy_q))
		else $error("partial grant not filled");
	a_whole_plain: assert property (@(posedge pclk) disable iff (!presetn) // R17
		tx_valid && !tx_frag |-> !tx_first && !tx_last && tx_piggy == 16'h0)
		else $error("whole frame flagged");
	a_start_req: assert property (@(posedge pclk) disable iff (!presetn) // R14
		start |=> req_valid && req_bytes == 16'($past(pwdata[31:16]) + phy_q))
		else $error("first request size");
	a_no_imm_frag: assert property (@(posedge pclk) disable iff (!presetn) // R12
		hit_grant && pwdata[UFF_G_IMM] |=> !(tx_valid && tx_frag && !tx_last))
		else $error("immediate fragmented");
	a_queued_zero: assert property (@(posedge pclk) disable iff (!presetn) // R15
		hit_grant && pwdata[UFF_G_MORE] |=> tx_piggy == 16'h0) else $error("piggy queued");
	a_ack_retry: assert property (@(posedge pclk) disable iff (!presetn) // R7
		state_q == UFF_WAIT && !hit_grant && timer_q == 16'h0 && retry_q < retry_max_q
		|=> state_q == UFF_BACK) else $error("no backoff after timeout");
	a_backoff_req: assert property (@(posedge pclk) disable iff (!presetn) // R7
		state_q == UFF_BACK && backoff_q == 16'h0 |=> req_valid) else $error("no re-request");
	a_drop_clear: assert property (@(posedge pclk) disable iff (!presetn) // R8
		state_q == UFF_DROP |=> remain_q == 16'h0 && state_q == UFF_IDLE)
		else $error("drop left data");
	a_drop_limit: assert property (@(posedge pclk) disable iff (!presetn) // R8
		state_q == UFF_WAIT && !hit_grant && timer_q == 16'h0 && retry_q >= retry_max_q
		|=> state_q == UFF_DROP) else $error("no drop at retry limit");
	a_retry_bound: assert property (@(posedge pclk) disable iff (!presetn) // R7
		state_q == UFF_BACK |-> retry_q <= retry_max_q && retry_q != 4'h0)
		else $error("retry bound");
	c_backoff: cover property (@(posedge pclk) disable iff (!presetn) state_q == UFF_BACK);
	c_fragment: cover property (@(posedge pclk) disable iff (!presetn) tx_valid && tx_first);
	c_last: cover property (@(posedge pclk) disable iff (!presetn) tx_valid && tx_last);
	c_whole: cover property (@(posedge pclk) disable iff (!presetn) tx_valid && !tx_frag);
	c_drop: cover property (@(posedge pclk) disable iff (!presetn) state_q == UFF_DROP);
endmodule

// *** verif/uff_headend_model.sv ***
/*
 Headend scheduler model: turns the latest request into a grant word.
 Assumes the bench writes that word to the grant register.
*/
module uff_headend_model (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic req_valid, // Request pulse
	input wire logic [15:0] req_bytes, // Requested bytes
	input wire logic tx_valid, // Descriptor pulse
	input wire logic tx_frag, // Fragment header present
	input wire logic tx_last, // Last flag
	input wire logic [15:0] tx_piggy, // Piggyback bytes
	input wire logic [15:0] cap, // Grant ceiling
	input wire logic multi, // Multiple-grant mode
	output logic [31:0] grant_word // Next map entry
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] need_q;
	logic [15:0] len;
	// Grant is cut to the ceiling, more entries flagged in multi mode
	assign len = (need_q < cap) ? need_q : cap;
	assign grant_word = {13'h0000, multi && (need_q > cap), 2'b00, len};
	// Track what is still owed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			need_q <= 16'h0000;
		end else if (req_valid) begin
			need_q <= req_bytes;
		end else if (tx_valid && tx_piggy != 16'h0000) begin
			need_q <= tx_piggy;
		end else if (tx_valid && tx_frag && !tx_last && multi) begin
			need_q <= need_q - len + 16'h0028;
		end
	end
endmodule

// *** verif/tb_top.sv ***
/*
 Bench for the fragmenter: APB master, scoreboard queue, scenarios.
 Assumes the headend model answers requests.
*/
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import uff_pkg::*;
	localparam logic [40:0] ALL = 41'h1FFFFFFFFFF;
	localparam logic [40:0] NO_EHDR = 41'h1FFFFFFFFFD;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic tx_valid, tx_frag, tx_first, tx_last, tx_piggy_ehdr, tx_encrypt;
	logic req_valid, multi, frag_on, enc_on;
	logic [31:0] paddr, pwdata, prdata, gw, r;
	logic [15:0] tx_payload, tx_piggy, req_bytes, cap, rem, len, fl;
	logic [3:0] tx_seq, seq;
	logic [40:0] got;
	logic [81:0] ent;
	logic [81:0] exp_q[$];
	int fails = 0, n_compared = 0, cycles = 0, k;
	assign got = {tx_payload, tx_frag, tx_first, tx_last, tx_seq, tx_piggy, tx_piggy_ehdr, tx_encrypt};
	uff_fragmenter #(.ACK_CYCLES(16'd20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .tx_valid(tx_valid),
		.tx_payload(tx_payload), .tx_frag(tx_frag), .tx_first(tx_first), .tx_last(tx_last),
		.tx_seq(tx_seq), .tx_piggy(tx_piggy), .tx_piggy_ehdr(tx_piggy_ehdr),
		.tx_encrypt(tx_encrypt), .req_valid(req_valid), .req_bytes(req_bytes));
	uff_headend_model hm (.pclk(pclk), .presetn(presetn), .req_valid(req_valid),
		.req_bytes(req_bytes), .tx_valid(tx_valid), .tx_frag(tx_frag), .tx_last(tx_last),
		.tx_piggy(tx_piggy), .cap(cap), .multi(multi), .grant_word(gw));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task finish_test;
		if (fails == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [40:0] s, input logic [40:0] x, input string m);
		n_compared++;
		if (s !== x) begin
			fails++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	// One APB transfer, result left in r and e; only the hang guard ends the wait
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h000000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wait_req(input logic [15:0] x);
		int n;
		n = 0;
		@(posedge pclk);
		while (req_valid !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		chk({24'h000000, req_valid, req_bytes}, {24'h000000, 1'b1, x}, "request");
		@(posedge pclk);
	endtask
	task setcap(input logic [15:0] v);
		cap <= v;
		@(posedge pclk);
	endtask
	task start(input logic [15:0] l, input logic [3:0] c);
		rem = l;
		seq = 4'h0;
		frag_on = 1'b0;
		enc_on = c[UFF_C_ENCRYPT];
		apb(1'b1, UFF_CTRL, {l, 12'h000, c});
		wait_req(l + UFF_PHY_OVH_RST);
	endtask
	// Write a grant word; when taken, note the descriptor it must yield
	task grant(input logic [31:0] w, input bit take);
		int n;
		logic [15:0] p, pg;
		n = 0;
		len = w[15:0];
		if (take) begin
			if (!frag_on && len >= rem + UFF_PHY_OVH_RST) begin
				exp_q.push_back({17'h1FFFF, 24'h000000, rem, 1'b0, 24'h000000});
			end else if (frag_on && len >= rem + UFF_FRAG_OVH + UFF_PHY_OVH_RST) begin
				exp_q.push_back({NO_EHDR, rem, 3'b101, seq, 16'h0000, 1'b0, enc_on});
				frag_on = 1'b0;
			end else begin
				p = len - UFF_FRAG_OVH - UFF_PHY_OVH_RST;
				pg = w[UFF_G_MORE] ? 16'h0000 : rem - p + UFF_FRAG_OVH + UFF_PHY_OVH_RST;
				exp_q.push_back({(pg != 0) ? ALL : NO_EHDR, p, 1'b1, !frag_on, 1'b0, seq, pg,
					1'b1, enc_on});
				rem = rem - p;
				seq++;
				frag_on = 1'b1;
			end
		end
		apb(1'b1, UFF_GRANT, w);
		while (exp_q.size() != 0 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		@(posedge pclk);
	endtask
	// Scoreboard: each descriptor against the oldest note
	always @(posedge pclk) begin
		if (tx_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk(41'h1, 41'h0, "unexpected descriptor");
			end else begin
				ent = exp_q.pop_front();
				chk(got & ent[81:41], ent[40:0] & ent[81:41], "descriptor");
			end
		end
	end
	// Hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test;
		end
	end
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		cap = 16'h07D0;
		multi = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		void'($urandom(78));
		apb(1'b0, UFF_RETRY, 32'h0);
		chk(41'(r), 41'h00080004, "retry reset");
		apb(1'b0, UFF_STAT, 32'h0);
		chk(41'(r), 41'h1, "status reset");
		apb(1'b0, 8'h24, 32'h0);
		chk(41'(e), 41'h1, "unmapped access");
		// Whole frame in one grant, interrupt masked
		fl = 16'($urandom % 512) + 16'h0040;
		start(fl, 4'hB);
		grant(gw, 1'b1);
		chk(41'(irq), 41'h0, "masked irq");
		// Piggyback mode, three encrypted fragments
		fl = 16'($urandom % 400) + 16'h0258;
		setcap(fl - 16'h0064);
		start(fl, 4'hF);
		grant(gw, 1'b1);
		setcap(16'h0064);
		grant(gw, 1'b1);
		grant(gw, 1'b1);
		// Multiple-grant mode with a pending entry first
		multi <= 1'b1;
		fl = 16'($urandom % 200) + 16'h00C8;
		setcap(fl >> 1);
		start(fl, 4'hB);
		grant(32'h00010000, 1'b0);
		grant(gw, 1'b1);
		setcap(16'h07D0);
		grant(gw, 1'b1);
		// Partial grant refused: immediate region, then flow disabled
		multi <= 1'b0;
		for (k = 0; k < 2; k++) begin
			fl = 16'($urandom % 100) + 16'h0064;
			setcap(fl >> 1);
			start(fl, k ? 4'h9 : 4'hB);
			grant(gw | (k ? 32'h0 : 32'h00020000), 1'b0);
			setcap(16'h07D0);
			grant(gw, 1'b1);
		end
		// Retries run out, frame dropped, interrupt raised and cleared
		apb(1'b1, UFF_IRQ, 32'hF);
		apb(1'b1, UFF_MASK, 32'h4);
		apb(1'b1, UFF_RETRY, 32'h00080001);
		fl = 16'($urandom % 100) + 16'h0064;
		start(fl, 4'hB);
		wait_req(fl + UFF_PHY_OVH_RST);
		k = 0;
		while (irq !== 1'b1 && k < 300) begin
			@(posedge pclk);
			k++;
		end
		chk(41'(irq), 41'h1, "drop irq");
		apb(1'b0, UFF_IRQ, 32'h0);
		chk(41'(r & 32'h4), 41'h4, "drop status");
		apb(1'b1, UFF_IRQ, 32'h4);
		@(posedge pclk);
		chk(41'(irq), 41'h0, "irq cleared");
		grant(gw, 1'b0);
		repeat (3) @(posedge pclk);
		chk(41'(exp_q.size()), 41'h0, "descriptors left");
		finish_test;
	end
endmodule
